// file: include/pmx_pkg.sv
// Package with the register map, field layout and per-pin constants of the pin multiplexer.
package pmx_pkg;

  localparam int unsigned PMX_NPINS = 8;
  localparam int unsigned PMX_NCODES = 4;
  localparam int unsigned PMX_AW = 12;

  // Register byte offsets.
  localparam logic [11:0] PMX_PINCTL_BASE = 12'h000;
  localparam logic [11:0] PMX_SUPPLY_STAT = 12'h020;
  localparam logic [3:0]  PMX_IDX_SUPPLY  = 4'h8;
  localparam logic [3:0]  PMX_IDX_NONE    = 4'hF;

  // Pin control field positions.
  localparam int unsigned PMX_F_MUX_LO  = 0;
  localparam int unsigned PMX_F_PG_LO   = 2;
  localparam int unsigned PMX_F_PULL_LO = 4;
  localparam int unsigned PMX_F_DIR     = 6;
  localparam int unsigned PMX_F_OD      = 7;
  localparam int unsigned PMX_F_OUTVAL  = 8;
  localparam int unsigned PMX_F_PADIN   = 16;
  localparam logic [31:0] PMX_WMASK     = 32'h0000_01FF;

  // Power gating field codes.
  localparam logic [1:0] PMX_PG_MAIN    = 2'h0;
  localparam logic [1:0] PMX_PG_RUNTIME = 2'h1;
  localparam logic [1:0] PMX_PG_ALWAYS  = 2'h2;

  // Pull field codes.
  localparam logic [1:0] PMX_PULL_UP   = 2'h1;
  localparam logic [1:0] PMX_PULL_DOWN = 2'h2;

  // Mux code that selects the GPIO itself.
  localparam logic [1:0] PMX_MUX_GPIO = 2'h0;

  // Pin control values after reset, index 0 is the first pin.
  localparam logic [7:0][31:0] PMX_PIN_RST = {
    32'h0000_0043, 32'h0000_0043, 32'h0000_0063, 32'h0000_0043,
    32'h0000_00A0, 32'h0000_0020, 32'h0000_0000, 32'h0000_0010};

  // Per pin, one bit per mux code: code exists.
  localparam logic [7:0][3:0] PMX_CODE_VALID = {
    4'h9, 4'h9, 4'h9, 4'h9, 4'h9, 4'h3, 4'h3, 4'h1};
  // Code is a peripheral output that owns the pad.
  localparam logic [7:0][3:0] PMX_CODE_ALTOUT = {
    4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h2, 4'h2, 4'h0};
  // Code fixes the buffer to push-pull whatever the drive type bit says.
  localparam logic [7:0][3:0] PMX_CODE_PP = {
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h2, 4'h0};
  // Input of this code follows the pad even while gated.
  localparam logic [7:0][3:0] PMX_GATE_NONE = {
    4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
  // Gated value is high rather than low.
  localparam logic [7:0][3:0] PMX_GATE_HIGH = {
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

endpackage

// file: design/pmx_sync.sv
// Two flip-flop synchroniser with a clock enable.
`timescale 1ns/1ns
`default_nettype none
module pmx_sync
  import pmx_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  input  wire logic [WIDTH-1:0] rst_val,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } pmx_sync_t;

  pmx_sync_t s_reg;
  pmx_sync_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (ce)
    begin
      s_next.meta = d;
      s_next.sync = s_reg.meta;
    end
  end

  // The reset value is a constant at every instance.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign q = s_reg.sync ^ ({WIDTH{1'b0}} & rst_val);

endmodule
`default_nettype wire

// file: design/pmx_pin_cell.sv
// Combinational multiplexer and power gating of one pin.
`timescale 1ns/1ns
`default_nettype none
module pmx_pin_cell
  import pmx_pkg::*;
#(
  parameter logic [3:0] VALID  = 4'h1,
  parameter logic [3:0] ALTOUT = 4'h0,
  parameter logic [3:0] PP     = 4'h0,
  parameter logic [3:0] GNONE  = 4'h1,
  parameter logic [3:0] GHIGH  = 4'h0
)(
  input  wire logic [31:0] ctl,
  input  wire logic [3:0]  alt_out,
  input  wire logic        supply_ok,
  input  wire logic        pad_in,
  output logic             pad_out,
  output logic             pad_oe,
  output logic             pull_up,
  output logic             pull_dn,
  output logic [3:0]       func_in
);

  logic [1:0] mux;
  logic [1:0] pg;
  logic       gated;
  logic       drive;
  logic       val;
  logic       od;

  always_comb
  begin
    mux = ctl[PMX_F_MUX_LO +: 2];
    pg  = ctl[PMX_F_PG_LO +: 2];
    // Only the runtime emulation code gates; always-on pins never do. [R8] [R12]
    gated = (pg == PMX_PG_RUNTIME) && !supply_ok; // [R15]
    if (mux == PMX_MUX_GPIO)
    begin
      drive = ctl[PMX_F_DIR];
      val   = ctl[PMX_F_OUTVAL];
    end
    else
    begin
      // Reserved codes leave the pad undriven. [R14]
      drive = VALID[mux] && ALTOUT[mux]; // [R1]
      val   = alt_out[mux];
    end
    // Buffer type of some alternates overrides the drive type bit. [R13]
    od = ctl[PMX_F_OD] && !((mux != PMX_MUX_GPIO) && PP[mux]);
    pad_out = od ? 1'b0 : val;
    // Output tri-states while the emulated supply is off. [R4]
    pad_oe  = drive && !gated && !(od && val);
    pull_up = ctl[PMX_F_PULL_LO +: 2] == PMX_PULL_UP; // [R10]
    pull_dn = ctl[PMX_F_PULL_LO +: 2] == PMX_PULL_DOWN; // [R10]
    for (int c = 0; c < 4; c++)
    begin
      // Gated value when unselected or unpowered, unless ungated. [R5] [R6] [R7] [R9]
      if (GNONE[c] || ((mux == c[1:0]) && VALID[c] && !gated))
        func_in[c] = pad_in;
      else
        func_in[c] = GHIGH[c];
    end
  end

endmodule
`default_nettype wire

// file: design/pmx_top.sv
// Pin function multiplexer with runtime supply emulation and an APB register slave.
// Operation
// [R1] Each GPIO pin carries the signal whose code matches its mux field.
// [R2] Reset loads each mux field with that pin's default code.
// [R3] A pin without a GPIO carries one fixed function and has no mux.
// [R4] Runtime-emulated outputs tri-state while the supply is not good.
// [R5] Runtime-emulated inputs are forced to their gated value while the supply is off.
// [R6] A peripheral input sees its gated value when unpowered or not selected.
// [R7] An ungated input always follows the pad.
// [R8] The power gating field picks the emulation; fixed functions have it fixed.
// [R9] Gating of an input function never changes what the pad drives.
// [R10] Pulls come from the pin control register with per-pin defaults.
// [R11] After reset pins show defaults and software may reprogram them.
// [R12] Always-on pins are never gated.
// [R13] Some alternates set the buffer type themselves.
// [R14] The mux field is two bits and reserved codes drive nothing.
// [R15] The supply-good input is synchronised before it gates anything.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module pmx_top
  import pmx_pkg::*;
(
  input  wire logic                 CLK,
  input  wire logic                 RSTN,
  input  wire logic                 CE,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [PMX_AW-1:0]    PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 RUNTIME_SUPPLY_GOOD,
  input  wire logic                 PRIVATE_SERIAL_MEM_CLOCK,
  input  wire logic                 SHARED_SERIAL_MEM_CLOCK,
  input  wire logic                 KEY_MATRIX_DRIVE_16,
  input  wire logic [3:0]           KEY_MATRIX_DRIVE_LOW,
  input  wire logic                 FIXED_FUNC_DRIVE,
  input  wire logic [7:0]           PAD_IN,
  output logic      [7:0]           PAD_OUT,
  output logic      [7:0]           PAD_OE,
  output logic      [7:0]           PAD_PU,
  output logic      [7:0]           PAD_PD,
  output logic      [31:0]          FUNC_IN,
  output logic                      FIXED_PAD_OUT,
  output logic                      FIXED_PAD_OE
);

  typedef struct packed {
    logic [7:0][31:0] ctl;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [7:0]       pad_out;
    logic [7:0]       pad_oe;
    logic [7:0]       pad_pu;
    logic [7:0]       pad_pd;
    logic [31:0]      func_in;
    logic             fix_out;
    logic             fix_oe;
  } pmx_state_t;

  pmx_state_t s_reg;
  pmx_state_t s_next;

  logic             rstn_s;
  logic             supply_ok;
  logic [7:0]       pad_in_s;
  logic [7:0][3:0]  alt_out;
  logic [7:0]       c_out;
  logic [7:0]       c_oe;
  logic [7:0]       c_pu;
  logic [7:0]       c_pd;
  logic [7:0][3:0]  c_fin;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and input synchronisers.

  pmx_sync #(.WIDTH(1)) u_rst_sync (
    .clk     (CLK),
    .rst_n   (RSTN),
    .ce      (1'b1),
    .d       (1'b1),
    .rst_val (1'b0),
    .q       (rstn_s)
  );

  pmx_sync #(.WIDTH(9)) u_in_sync (
    .clk     (CLK),
    .rst_n   (rstn_s),
    .ce      (CE),
    .d       ({RUNTIME_SUPPLY_GOOD, PAD_IN}),
    .rst_val (9'h000),
    .q       ({supply_ok, pad_in_s}) // [R15]
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Pin cells.

  always_comb
  begin
    alt_out = '0;
    alt_out[1][1] = PRIVATE_SERIAL_MEM_CLOCK;
    alt_out[2][1] = SHARED_SERIAL_MEM_CLOCK;
    alt_out[3][3] = KEY_MATRIX_DRIVE_16;
    for (int p = 4; p < 8; p++)
      alt_out[p][3] = KEY_MATRIX_DRIVE_LOW[7-p];
  end

  for (genvar g = 0; g < PMX_NPINS; g++)
  begin : g_pin
    pmx_pin_cell #(
      .VALID  (PMX_CODE_VALID[g]),
      .ALTOUT (PMX_CODE_ALTOUT[g]),
      .PP     (PMX_CODE_PP[g]),
      .GNONE  (PMX_GATE_NONE[g]),
      .GHIGH  (PMX_GATE_HIGH[g])
    ) u_cell (
      .ctl       (s_reg.ctl[g]),
      .alt_out   (alt_out[g]),
      .supply_ok (supply_ok),
      .pad_in    (pad_in_s[g]),
      .pad_out   (c_out[g]),
      .pad_oe    (c_oe[g]),
      .pull_up   (c_pu[g]),
      .pull_dn   (c_pd[g]),
      .func_in   (c_fin[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode, access and output registers.

  function automatic logic [3:0] pmx_index(input logic [PMX_AW-1:0] a);
    logic [3:0] r;
    r = PMX_IDX_NONE;
    if (a[1:0] == 2'h0)
    begin
      if (a == PMX_SUPPLY_STAT)
        r = PMX_IDX_SUPPLY;
      else if (a >= PMX_PINCTL_BASE && a < PMX_SUPPLY_STAT)
        r = {1'b0, a[4:2]};
    end
    return r;
  endfunction

  always_comb
  begin
    logic [3:0] idx;
    idx    = pmx_index(PADDR);
    s_next = s_reg;
    if (CE)
    begin
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
      if (PSEL && PENABLE && !s_reg.pready)
      begin
        s_next.pready = 1'b1;
        s_next.prdata = 32'h0000_0000;
        if (idx == PMX_IDX_SUPPLY)
          s_next.prdata[0] = supply_ok;
        else if (idx == PMX_IDX_NONE)
          s_next.pslverr = 1'b1;
        else
        begin
          s_next.prdata = s_reg.ctl[idx[2:0]];
          s_next.prdata[PMX_F_PADIN] = pad_in_s[idx[2:0]];
        end
      end
      // Software reprograms mux, direction, drive and pulls. [R11]
      if (PSEL && PENABLE && s_reg.pready && PWRITE && !idx[3])
        s_next.ctl[idx[2:0]] = (s_reg.ctl[idx[2:0]] & ~PMX_WMASK) | (PWDATA & PMX_WMASK);
      s_next.pad_out = c_out;
      s_next.pad_oe  = c_oe;
      s_next.pad_pu  = c_pu;
      s_next.pad_pd  = c_pd;
      s_next.func_in = c_fin;
      // Fixed pin on the emulated runtime domain, no mux logic. [R3] [R8]
      s_next.fix_out = FIXED_FUNC_DRIVE;
      s_next.fix_oe  = supply_ok; // [R4]
    end
  end

  always_ff @(posedge CLK or negedge rstn_s)
  begin
    if (!rstn_s)
    begin
      s_reg     <= '0;
      s_reg.ctl <= PMX_PIN_RST; // [R2]
    end
    else
      s_reg <= s_next;
  end

  assign PRDATA        = s_reg.prdata;
  assign PREADY        = s_reg.pready;
  assign PSLVERR       = s_reg.pslverr;
  assign PAD_OUT       = s_reg.pad_out;
  assign PAD_OE        = s_reg.pad_oe;
  assign PAD_PU        = s_reg.pad_pu;
  assign PAD_PD        = s_reg.pad_pd;
  assign FUNC_IN       = s_reg.func_in;
  assign FIXED_PAD_OUT = s_reg.fix_out;
  assign FIXED_PAD_OE  = s_reg.fix_oe;

endmodule
`default_nettype wire

// file: testbench/pmx_pad_model.sv
// Pad ring model: resolves each pad from the block, an outside driver and the pulls.
`timescale 1ns/1ns
`default_nettype none
module pmx_pad_model (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pu,
  input  wire logic [7:0] pad_pd,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_lvl
);
  logic flip_reg = 1'b0;
  // A floating pad without a pull reads a level that changes every cycle.
  always @(posedge clk) flip_reg <= !flip_reg;
  always_comb
    for (int i = 0; i < 8; i++)
      pad_lvl[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                   pad_pu[i] | !pad_pd[i] & flip_reg;
endmodule
`default_nettype wire

// file: testbench/pmx_top_asserts.sv
// Port assertions of the pin multiplexer, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module pmx_top_asserts
  import pmx_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              CE,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [PMX_AW-1:0] PADDR,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              RUNTIME_SUPPLY_GOOD,
  input wire logic              FIXED_FUNC_DRIVE,
  input wire logic              FIXED_PAD_OUT,
  input wire logic              FIXED_PAD_OE
);
  logic [3:0] age_reg;
  logic       bad;
  logic       up;
  assign bad = PADDR > 12'h020 || PADDR[1:0] != 2'h0;
  assign up  = age_reg == 4'hF && CE;
  // Skips the reset release and synchroniser fill.
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
      age_reg <= 4'h0;
    else if (age_reg != 4'hF)
      age_reg <= age_reg + 4'h1;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ////////////////////////////////////////////////////////////
  a_ready_next: assert property (PSEL && PENABLE && !PREADY && CE |=> PREADY)
    else $error("Ready missing.");
  a_ready_once: assert property (PREADY && CE |=> !PREADY)
    else $error("Ready held.");
  a_err_unmapped: assert property (PREADY && bad |-> PSLVERR)
    else $error("No slave error.");
  a_err_mapped: assert property (PREADY && !bad |-> !PSLVERR)
    else $error("Spurious slave error.");
  a_rd_err_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
    else $error("Error read not zero.");
  a_fixed_oe_on: assert property ((up && RUNTIME_SUPPLY_GOOD)[*4] |=> FIXED_PAD_OE)
    else $error("Fixed pin not driven.");
  a_fixed_oe_off: assert property ((up && !RUNTIME_SUPPLY_GOOD)[*4] |=> !FIXED_PAD_OE)
    else $error("Fixed pin not released.");
  a_fixed_follows: assert property (FIXED_PAD_OE && $past(FIXED_PAD_OE) && $past(CE)
    |-> FIXED_PAD_OUT == $past(FIXED_FUNC_DRIVE))
    else $error("Fixed pin value wrong.");
endmodule
bind pmx_top pmx_top_asserts i_pmx_top_asserts (
  .CLK, .RSTN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .RUNTIME_SUPPLY_GOOD, .FIXED_FUNC_DRIVE, .FIXED_PAD_OUT, .FIXED_PAD_OE);
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the pin multiplexer with random pin setups.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pmx_pkg::*;
;
  logic        CLK = 1'b0;
  logic        RSTN, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RUNTIME_SUPPLY_GOOD, s, g, err;
  logic        PRIVATE_SERIAL_MEM_CLOCK, SHARED_SERIAL_MEM_CLOCK, KEY_MATRIX_DRIVE_16;
  logic        FIXED_FUNC_DRIVE, FIXED_PAD_OUT, FIXED_PAD_OE;
  logic [3:0]  KEY_MATRIX_DRIVE_LOW;
  logic [11:0] PADDR;
  logic [7:0]  PAD_IN, PAD_OUT, PAD_OE, PAD_PU, PAD_PD, ext_en, ext_val;
  logic [7:0]  av, xv, eoe, eo, lvl, pu, pd;
  logic [31:0] PWDATA, PRDATA, FUNC_IN, rd, efi;
  logic [31:0] ctl [8];
  int          miscompares = 0;
  int          n_checks = 0;
  always #5 CLK = ~CLK;
  pmx_top i_pmx_top (
    .CLK, .RSTN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .RUNTIME_SUPPLY_GOOD, .PRIVATE_SERIAL_MEM_CLOCK, .SHARED_SERIAL_MEM_CLOCK,
    .KEY_MATRIX_DRIVE_16, .KEY_MATRIX_DRIVE_LOW, .FIXED_FUNC_DRIVE, .PAD_IN, .PAD_OUT,
    .PAD_OE, .PAD_PU, .PAD_PD, .FUNC_IN, .FIXED_PAD_OUT, .FIXED_PAD_OE);
  pmx_pad_model i_pmx_pad_model (.clk(CLK), .pad_out(PAD_OUT), .pad_oe(PAD_OE),
    .pad_pu(PAD_PU), .pad_pd(PAD_PD), .ext_en, .ext_val, .pad_lvl(PAD_IN));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL    <= 1'b1;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Ready and read data are taken at the rising edge that sees ready high.
    do @(posedge CLK); while (PREADY !== 1'b1 && ++n < 40);
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 40) cmp("apb wait", 32'h0, 32'h1);
  endtask
  task automatic do_reset();
    RSTN <= 1'b0;
    repeat (5) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge CLK);
    cmp("reset pulls", 32'h012C, {16'h0, PAD_PU, PAD_PD});
    cmp("reset oe", 32'hF0, {24'h0, PAD_OE});
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 12'(4 * i), '0);
      cmp("reset ctl", PMX_PIN_RST[i], rd & 32'h1FF);
    end
  endtask
  function automatic void predict();
    logic [1:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = ctl[i][1:0];
      g = ctl[i][3:2] == PMX_PG_RUNTIME && !s;
      eo[i] = PMX_CODE_ALTOUT[i][m] ? av[i] : ctl[i][8] && !ctl[i][7];
      eoe[i] = !g && (PMX_CODE_ALTOUT[i][m] || m == PMX_MUX_GPIO && ctl[i][6]
               && !(ctl[i][7] && ctl[i][8]));
      lvl[i] = eoe[i] ? eo[i] : xv[i];
      pu[i] = ctl[i][5:4] == PMX_PULL_UP;
      pd[i] = ctl[i][5:4] == PMX_PULL_DOWN;
      for (int k = 0; k < 4; k++)
      begin
        efi[4 * i + k] = (k == 0 || k == m && PMX_CODE_VALID[i][k] && !g) && lvl[i];
      end
    end
  endfunction
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    {RSTN, PSEL, PENABLE, PWRITE, RUNTIME_SUPPLY_GOOD, FIXED_FUNC_DRIVE, PADDR, PWDATA} = '0;
    {PRIVATE_SERIAL_MEM_CLOCK, SHARED_SERIAL_MEM_CLOCK, KEY_MATRIX_DRIVE_16} = '0;
    {KEY_MATRIX_DRIVE_LOW, ext_en, ext_val} = '0;
    CE = 1'b1;
    void'($urandom(99));
    do_reset();
    for (int it = 0; it < 40; it++)
    begin
      s  = it < 2 ? 1'b0 : 1'($urandom);
      av = 8'($urandom);
      xv = 8'($urandom);
      RUNTIME_SUPPLY_GOOD      <= s;
      FIXED_FUNC_DRIVE         <= av[0];
      PRIVATE_SERIAL_MEM_CLOCK <= av[1];
      SHARED_SERIAL_MEM_CLOCK  <= av[2];
      KEY_MATRIX_DRIVE_16      <= av[3];
      KEY_MATRIX_DRIVE_LOW     <= {av[4], av[5], av[6], av[7]};
      for (int i = 0; i < 8; i++)
      begin
        ctl[i] = $urandom;
        if (it < 2) ctl[i][3:2] = 2'(it + 1);
        if (ctl[i][5:4] == 2'h3) ctl[i][5:4] = 2'h0;
        if (ctl[i][1:0] != PMX_MUX_GPIO && !PMX_CODE_PP[i][ctl[i][1:0]]) ctl[i][7] = 1'b0;
        apb(1'b1, 12'(4 * i), ctl[i]);
      end
      apb(1'b1, PMX_SUPPLY_STAT, '1);
      apb(it[0], it == 0 ? 12'h002 : 12'($urandom_range(12'hFFF, 12'h021)), '1);
      cmp("unmapped err", 32'h1, {31'h0, err});
      predict();
      ext_val <= xv;
      ext_en  <= ~eoe;
      repeat (6) @(posedge CLK);
      cmp("pad oe", {24'h0, eoe}, {24'h0, PAD_OE});
      cmp("pad out", {24'h0, eo & eoe}, {24'h0, PAD_OUT & eoe});
      cmp("pulls", {16'h0, pu, pd}, {16'h0, PAD_PU, PAD_PD});
      cmp("func in", efi, FUNC_IN);
      cmp("fixed pin", {30'h0, s, av[0]}, {30'h0, FIXED_PAD_OE, FIXED_PAD_OUT});
      for (int i = 0; i < 8; i++)
      begin
        apb(1'b0, 12'(4 * i), '0);
        cmp("ctl read", ctl[i] & 32'h1FF | {15'h0, lvl[i], 16'h0}, rd & 32'h101FF);
      end
      apb(1'b0, PMX_SUPPLY_STAT, '0);
      cmp("supply status", {31'h0, s}, rd);
      cmp("mapped err", 32'h0, {31'h0, err});
      if (it == 5)
      begin
        // With the clock enable low the synchronised supply must not move.
        CE                  <= 1'b0;
        RUNTIME_SUPPLY_GOOD <= !s;
        repeat (6) @(posedge CLK);
        cmp("ce freeze", {31'h0, s}, {31'h0, FIXED_PAD_OE});
        CE <= 1'b1;
      end
    end
    do_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
